//--- hw/clst_tracker.sv
// Closed-loop supply tracker: sequences four tracked channels with ramp control.
// Assumes comparator results and slot events arrive synchronous to clk.
// Operation
// - Tracking allowed except first and final slots
// - Channel groups monitor, enable, sense by index
// - Monitor valid at slot start before tracking
// - Track immediately; fault on timeout expiry
// - Pause ramp while any channel lags
// - Timeout from two-bit field; pauses ignored
// - Spread fault drops enables, logs fault
// - Fault pin asserts when so configured
// - Channel follows ramp until supply good
// - Supply good gives full gate drive
// - Two-bit slew rate field selects ramp
// - Power-down on enable low or bit
// - Reverse bit selects falling tracked ramp
// - Fast fall aborts, all enables off
// - Reverse clear drops all enables together
// - Pulldown only where its bit set
// - Pulldowns applied only in discharge
// - Pulldowns usable on untracked channels
// - Two-bit per-channel supply-good thresholds
// - Timeout codes 25, 50, 100, 200 ms
// - Recovery bit selects autoretry or latch
`timescale 1ns/10ps
`default_nettype none
module clst_tracker #(
   parameter int unsigned TMO_BASE_CYC = clst_pkg::TMO_CYC_0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sequencer context
   input wire logic slot_start,
   input wire logic [3:0] slot_num,
   input wire logic en_pin,
   // Comparator outcomes
   input wire clst_pkg::clst_cmp_t cmp,
   // Analog control
   output logic [clst_pkg::NCH-1:0] chan_enable,
   output logic [clst_pkg::NCH-1:0] chan_full_drive,
   output logic [clst_pkg::NCH-1:0] sense_pulldown,
   output logic ramp_run,
   output logic ramp_down,
   output logic [1:0] ramp_slew,
   output logic [1:0] supply_good_thr [clst_pkg::NCH],
   output logic tracking_fault_output,
   output logic fault_log_stb,
   output logic [1:0] fault_log_id,
   output logic retry_request
);
   import clst_pkg::*;

   clst_state_s_t s_q, s_d;
   logic wr, rd_hit;
   logic [NCH-1:0] trk_en;

   // Timeout code to cycles; base doubles per code
   function automatic logic [31:0] tmo_cyc(input logic [1:0] code);
      tmo_cyc = 32'(TMO_BASE_CYC) << code;
   endfunction : tmo_cyc

   assign wr = psel && penable && pwrite;
   assign trk_en = s_q.trk[NCH-1:0];

   // Bus answers in the access phase with no wait
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_hit;
   assign prdata = s_q.prdata;

   always_comb begin
      unique case (paddr)
         OFF_CTRL, OFF_TMO, OFF_RETRY, OFF_REV, OFF_THR, OFF_TRK, OFF_STAT: rd_hit = 1'b1;
         default: rd_hit = 1'b0;
      endcase
   end

   // Next-state logic for all control state
   always_comb begin
      s_d = s_q;
      s_d.log_stb = 1'b0;
      if (wr) begin
         unique case (paddr)
            OFF_CTRL: s_d.ctrl = pwdata[7:0];
            OFF_TMO: s_d.tmo = pwdata[7:0];
            OFF_RETRY: s_d.retry = pwdata[7:0];
            OFF_REV: s_d.rev = pwdata[7:0];
            OFF_THR: s_d.thr = pwdata[7:0];
            OFF_TRK: s_d.trk = pwdata[7:0];
            default: ;
         endcase
      end
      // Read data from flops, captured in setup
      if (psel && !penable) begin
         unique case (paddr)
            OFF_CTRL: s_d.prdata = {24'h000000, s_q.ctrl};
            OFF_TMO: s_d.prdata = {24'h000000, s_q.tmo};
            OFF_RETRY: s_d.prdata = {24'h000000, s_q.retry};
            OFF_REV: s_d.prdata = {24'h000000, s_q.rev};
            OFF_THR: s_d.prdata = {24'h000000, s_q.thr};
            OFF_TRK: s_d.prdata = {24'h000000, s_q.trk};
            OFF_STAT: s_d.prdata = {16'h0000, s_q.st, s_q.fault, s_q.fault_id,
                                    s_q.full, s_q.en};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      s_d.cnt = s_q.cnt + 32'h00000001;
      unique case (s_q.st)
         ST_OFF: begin
            s_d.pull = '0;
            s_d.cnt = '0;
            // Slot 0 and final slot never track
            if (slot_start && slot_num != 4'h0 && slot_num < 4'hC && trk_en != '0
                && en_pin && !s_q.ctrl[F_SWPD]) begin
               s_d.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Monitor inputs must be valid first
            if ((cmp.mon_ok & trk_en) == trk_en) begin
               s_d.st = ST_TRACK;
               s_d.en = trk_en;
               s_d.ramp_run = 1'b1;
            end else if (s_q.cnt >= tmo_cyc(s_q.tmo[F_PUTMO +: 2])) begin
               s_d.st = ST_FAULT;
               s_d.fault_id = FAULT_ID_TMO;
            end
         end
         ST_TRACK: begin
            s_d.ramp_run = ((cmp.lag & trk_en) == '0);
            s_d.full = s_q.full | (cmp.good & trk_en);
            if (cmp.spread) begin
               s_d.st = ST_FAULT;
               s_d.fault_id = FAULT_ID_SPREAD;
            end else if (!en_pin || s_q.ctrl[F_SWPD]) begin
               s_d.ramp_run = 1'b0;
               s_d.full = '0;
               s_d.cnt = '0;
               if (s_q.rev[F_REV]) begin
                  s_d.st = ST_DOWN;
                  s_d.ramp_dn = 1'b1;
                  s_d.ramp_run = 1'b1;
               end else begin
                  s_d.st = ST_OFF;
                  s_d.en = '0;
                  s_d.pull = s_q.tmo[F_PULL +: NCH];
               end
            end else if (s_d.full == trk_en) begin
               s_d.ramp_run = 1'b0;
               s_d.cnt = s_q.cnt;
            end else if (s_q.cnt >= tmo_cyc(s_q.tmo[F_PUTMO +: 2])) begin
               s_d.st = ST_FAULT;
               s_d.fault_id = FAULT_ID_TMO;
            end
         end
         ST_DOWN: begin
            s_d.ramp_run = ((cmp.lag & trk_en) == '0);
            if ((cmp.fast_fall & trk_en) != '0 || (cmp.mon_ok & trk_en) != trk_en
                || cmp.spread) begin
               s_d.st = ST_FAULT;
               s_d.fault_id = FAULT_ID_PD;
            end else if ((cmp.good & trk_en) == '0 && s_q.cnt > 32'h00000001) begin
               s_d.st = ST_OFF;
               s_d.en = '0;
               s_d.ramp_run = 1'b0;
               s_d.ramp_dn = 1'b0;
               s_d.pull = s_q.tmo[F_PULL +: NCH];
            end else if (s_q.cnt >= tmo_cyc(s_q.tmo[F_PDTMO +: 2])) begin
               s_d.st = ST_FAULT;
               s_d.fault_id = FAULT_ID_TMO;
            end
         end
         ST_FAULT: begin
            // Latched until recovery; autoretry hands back to the slot sequencer
            s_d.cnt = '0;
            if (!s_q.retry[F_LATCH] && !en_pin) begin
               s_d.st = ST_OFF;
               s_d.fault = 1'b0;
               s_d.pull = '0;
            end
         end
         default: s_d.st = ST_OFF;
      endcase
      // Common fault entry: all enables low and one log strobe
      if (s_d.st == ST_FAULT && s_q.st != ST_FAULT) begin
         s_d.en = '0;
         s_d.full = '0;
         s_d.ramp_run = 1'b0;
         s_d.ramp_dn = 1'b0;
         s_d.fault = 1'b1;
         s_d.log_stb = 1'b1;
         s_d.pull = s_q.tmo[F_PULL +: NCH];
      end
      // Untracked channels still get shutdown discharge
      if (s_q.st == ST_OFF && (!en_pin || s_q.ctrl[F_SWPD])) begin
         s_d.pull = s_q.tmo[F_PULL +: NCH] & ~trk_en;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '{st: ST_OFF, prdata: 32'h00000000, cnt: 32'h00000000, fault_id: 2'h0,
                  default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Per-channel threshold fields out to the comparators
   for (genvar i = 0; i < NCH; i++) begin : g_thr
      assign supply_good_thr[i] = s_q.thr[2*i +: 2];
   end

   assign chan_enable = s_q.en;
   assign chan_full_drive = s_q.full;
   assign sense_pulldown = s_q.pull;
   assign ramp_run = s_q.ramp_run;
   assign ramp_down = s_q.ramp_dn;
   assign ramp_slew = s_q.retry[F_SLEW +: 2];
   assign tracking_fault_output = s_q.fault && s_q.trk[F_GPIO6];
   assign fault_log_stb = s_q.log_stb;
   assign fault_log_id = s_q.fault_id;
   assign retry_request = s_q.fault && !s_q.retry[F_LATCH];
endmodule : clst_tracker
`default_nettype wire

//--- hw/clst_pkg.sv
// Constants and carrier types for the closed-loop supply tracker.
// Assumes a 100 MHz system clock and an APB register bus.
package clst_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned NCH = 4;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h4D;
   localparam logic [7:0] OFF_TMO = 8'h4E;
   localparam logic [7:0] OFF_RETRY = 8'h4F;
   localparam logic [7:0] OFF_REV = 8'h54;
   localparam logic [7:0] OFF_THR = 8'h64;
   localparam logic [7:0] OFF_TRK = 8'h70;
   localparam logic [7:0] OFF_STAT = 8'h74;
   // Field positions
   localparam int unsigned F_SWPD = 0;
   localparam int unsigned F_PUTMO = 0;
   localparam int unsigned F_PDTMO = 2;
   localparam int unsigned F_PULL = 4;
   localparam int unsigned F_LATCH = 3;
   localparam int unsigned F_SLEW = 4;
   localparam int unsigned F_REV = 4;
   localparam int unsigned F_GPIO6 = 4;
   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   // Fault timeouts in ms, and cycles derived from the clock rate
   localparam int unsigned TMO_MS_0 = 25;
   localparam int unsigned TMO_CYC_0 = TMO_MS_0 * 1000 * CLK_MHZ;
   localparam logic [1:0] FAULT_ID_SPREAD = 2'h1;
   localparam logic [1:0] FAULT_ID_TMO = 2'h2;
   localparam logic [1:0] FAULT_ID_PD = 2'h3;

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_WAIT = 5'h02,
      ST_TRACK = 5'h04,
      ST_DOWN = 5'h08,
      ST_FAULT = 5'h10
   } clst_state_t;

   // Comparator outcomes per channel, plus one shared spread flag
   typedef struct packed {
      logic [NCH-1:0] mon_ok;
      logic [NCH-1:0] lag;
      logic [NCH-1:0] good;
      logic [NCH-1:0] fast_fall;
      logic spread;
   } clst_cmp_t;

   typedef struct packed {
      clst_state_t st;
      logic [7:0] ctrl;
      logic [7:0] tmo;
      logic [7:0] retry;
      logic [7:0] rev;
      logic [7:0] thr;
      logic [7:0] trk;
      logic [31:0] cnt;
      logic [NCH-1:0] en;
      logic [NCH-1:0] full;
      logic [NCH-1:0] pull;
      logic ramp_run;
      logic ramp_dn;
      logic fault;
      logic [1:0] fault_id;
      logic log_stb;
      logic [31:0] prdata;
   } clst_state_s_t;
endpackage : clst_pkg

//--- verif/clst_checker.sv
// Port assertions for the supply tracker.
// Bound to clst_tracker below; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module clst_checker import clst_pkg::*; #(
   parameter int unsigned TMO_BASE_CYC = 50
) (
   // Clock, reset, bus
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   // Tracking
   input wire logic en_pin,
   input wire clst_pkg::clst_cmp_t cmp,
   input wire logic [NCH-1:0] chan_enable,
   input wire logic [NCH-1:0] chan_full_drive,
   input wire logic [NCH-1:0] sense_pulldown,
   input wire logic ramp_run,
   input wire logic ramp_down,
   input wire logic [1:0] supply_good_thr [NCH],
   input wire logic fault_log_stb,
   input wire logic [1:0] fault_log_id
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_THR: assert property (psel && penable && pwrite && paddr == OFF_THR
      |=> supply_good_thr[3] == $past(pwdata[7:6])) else $error("threshold not loaded");
   AST_SPREAD: assert property (cmp.spread && |chan_enable && !ramp_down
      |=> chan_enable == 4'h0 && fault_log_id == FAULT_ID_SPREAD) else $error("spread kept on");
   AST_LOG: assert property (fault_log_stb |=> !fault_log_stb) else $error("log not a pulse");
   AST_PAUSE: assert property (ramp_run |-> $past(cmp.lag) == 4'h0) else $error("ramp ran");
   AST_FULL: assert property ((chan_full_drive & ~$past(chan_full_drive) & ~$past(cmp.good))
      == 4'h0) else $error("full drive without good");
   // Pulldowns belong to discharge only, never beside a live enable
   AST_PULL: assert property (|sense_pulldown |-> chan_enable == 4'h0) else $error("pull on");
   AST_ENLOW: assert property ($fell(en_pin) && |chan_enable |=> chan_enable == 4'h0 || ramp_down)
      else $error("no power-down");
   AST_FAST: assert property (ramp_down && |(cmp.fast_fall & chan_enable)
      |=> chan_enable == 4'h0) else $error("fast fall kept on");
endmodule : clst_checker
bind clst_tracker clst_checker #(.TMO_BASE_CYC(TMO_BASE_CYC)) u_clst_checker (.clk(clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .en_pin(en_pin), .cmp(cmp), .chan_enable(chan_enable),
   .chan_full_drive(chan_full_drive), .sense_pulldown(sense_pulldown), .ramp_run(ramp_run),
   .ramp_down(ramp_down), .supply_good_thr(supply_good_thr), .fault_log_stb(fault_log_stb),
   .fault_log_id(fault_log_id));
`default_nettype wire

//--- verif/clst_partner.sv
// Model of the switched supplies and their comparators.
// Faults and lag appear only when the bench commands them.
`timescale 1ns/10ps
`default_nettype none
module clst_partner import clst_pkg::*; (
   // Clock and commands
   input wire logic clk,
   input wire logic [4:0] fault_req,
   input wire logic [NCH-1:0] lag_req,
   // Tracker side
   input wire logic [NCH-1:0] chan_enable,
   input wire logic ramp_run,
   input wire logic ramp_down,
   output clst_pkg::clst_cmp_t cmp
);
   int lvl [NCH] = '{default: 0};
   // Level climbs with the ramp, sinks when switched off or ramped down
   always @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (chan_enable[i] && ramp_run && !ramp_down && lvl[i] < 6) lvl[i] <= lvl[i] + 1;
         else if ((ramp_down || !chan_enable[i]) && lvl[i] > 0) lvl[i] <= lvl[i] - 1;
      end
   end
   always_comb begin
      for (int i = 0; i < NCH; i++) cmp.good[i] = lvl[i] >= 6;
      cmp.lag = lag_req & chan_enable;
      cmp.mon_ok = 4'hF;
      cmp.fast_fall = fault_req[3:0] & chan_enable;
      cmp.spread = fault_req[4];
   end
endmodule : clst_partner
`default_nettype wire

//--- verif/clst_tracker_tb.sv
// Bench for the supply tracker against a register model.
// Assumes the partner model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module clst_tracker_tb;
   import clst_pkg::*;
   localparam int TB = 50;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, sst = 0, en_pin = 1;
   logic pready, pslverr, err, rr, rd_n, tfo, stb, rq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] slot = 4'h0, lag = 4'h0, en, full, pull;
   logic [4:0] fq = 5'h00;
   logic [1:0] slew, id, thr [NCH];
   clst_cmp_t cmp;
   int n_mismatch = 0, tests_run = 0, cyc = 0, k, seed = 98393, mdl [256];
   always #5 clk = ~clk;
   clst_tracker #(.TMO_BASE_CYC(TB)) u_clst_tracker (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slot_start(sst), .slot_num(slot), .en_pin(en_pin),
      .cmp(cmp), .chan_enable(en), .chan_full_drive(full), .sense_pulldown(pull),
      .ramp_run(rr), .ramp_down(rd_n), .ramp_slew(slew), .supply_good_thr(thr),
      .tracking_fault_output(tfo), .fault_log_stb(stb), .fault_log_id(id), .retry_request(rq));
   clst_partner u_clst_partner (.clk(clk), .fault_req(fq), .lag_req(lag), .chan_enable(en),
      .ramp_run(rr), .ramp_down(rd_n), .cmp(cmp));
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Setup then access; released only after the edge that sees pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      for (k = 0; pready !== 1'b1 && k < 20; k++) @(posedge clk);
      chk(32'(pready), 1, "pready");
      rd = prdata;
      err = pslverr;
      if (wr) mdl[a] = d[7:0];
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : apb
   task up(input logic [3:0] s);
      slot <= s;
      sst <= 1;
      @(posedge clk);
      sst <= 0;
      repeat (3) @(posedge clk);
   endtask : up
   task wt(input logic [3:0] v, input logic on_full);
      for (k = 0; k < 90 && (on_full ? full : en) !== v; k++) @(posedge clk);
   endtask : wt
   task results;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // Hang guard well above the planned run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      apb(0, OFF_THR, 0);
      chk(rd, 32'(RST_REG), "thr rst");
      apb(1, OFF_THR, 32'hE4);
      for (int i = 0; i < NCH; i++) chk(32'(thr[i]), 32'(i), "thr code");
      apb(1, OFF_THR, $random(seed));
      apb(0, OFF_THR, 0);
      chk(rd, 32'(mdl[OFF_THR]), "thr rd");
      apb(1, 8'h10, 32'hFF);
      chk(32'(err), 1, "slverr");
      apb(0, 8'h10, 0);
      chk(rd, 0, "unmapped");
      apb(1, OFF_TRK, 32'h1F);
      apb(1, OFF_TMO, 32'hA0);
      apb(1, OFF_RETRY, $random(seed) & 32'h30);
      chk(32'(slew), 32'(mdl[OFF_RETRY] >> 4), "slew");
      apb(1, OFF_REV, 32'h10);
      for (int s = 0; s <= 12; s += 12) begin
         up(4'(s));
         chk(32'(en), 0, "edge slot");
      end
      up(4'h3);
      chk(32'(en), 32'hF, "enables");
      lag <= 4'h2;
      repeat (3) @(posedge clk);
      chk(32'(rr), 0, "pause");
      lag <= 4'h0;
      repeat (3) @(posedge clk);
      chk(32'(rr), 1, "resume");
      wt(4'hF, 1);
      chk(32'(full), 32'hF, "full");
      en_pin <= 0;
      repeat (2) @(posedge clk);
      chk(32'(rd_n), 1, "rev down");
      wt(4'h0, 0);
      chk(32'(en), 0, "rev off");
      en_pin <= 1;
      apb(1, OFF_REV, 0);
      up(4'h5);
      wt(4'hF, 1);
      apb(1, OFF_CTRL, 1);
      @(posedge clk);
      chk(32'(en), 0, "sim off");
      apb(1, OFF_CTRL, 0);
      up(4'h7);
      fq <= 5'h10;
      repeat (2) @(posedge clk);
      chk({en, stb, id, tfo, pull, rq}, {4'h0, 1'b1, FAULT_ID_SPREAD, 1'b1, 4'hA, 1'b1}, "spread");
      fq <= 5'h00;
      en_pin <= 0;
      repeat (10) @(posedge clk);
      en_pin <= 1;
      @(posedge clk);
      chk(32'(pull), 0, "pull idle");
      up(4'h9);
      lag <= 4'hF;
      for (k = 0; k < 90 && stb !== 1'b1; k++) @(posedge clk);
      chk({30'(k >= TB - 10 && k <= TB), id}, {30'h1, FAULT_ID_TMO}, "timeout");
      lag <= 4'h0;
      en_pin <= 0;
      repeat (10) @(posedge clk);
      en_pin <= 1;
      apb(1, OFF_REV, 32'h10);
      up(4'hB);
      wt(4'hF, 1);
      en_pin <= 0;
      repeat (2) @(posedge clk);
      fq <= 5'h01;
      repeat (2) @(posedge clk);
      chk({en, id}, {4'h0, FAULT_ID_PD}, "fast fall");
      results();
   end
endmodule : clst_tracker_tb
`default_nettype wire
